// ### core/sllsel_map.vh
/*
 * Register offsets, field positions, reset values and default settings
 * for the signal-loss level select block.
 * Assumes it is included by bare name and read by plain Verilog-2005 files.
 */
`ifndef SLLSEL_MAP_VH
`define SLLSEL_MAP_VH

`define SLLSEL_OFF_LEVEL_A   8'h00
`define SLLSEL_OFF_LEVEL_B   8'h04
`define SLLSEL_OFF_LEVEL_C   8'h08
`define SLLSEL_OFF_LEVEL_D   8'h0c
`define SLLSEL_OFF_BW_A      8'h10
`define SLLSEL_OFF_BW_B      8'h14
`define SLLSEL_OFF_BW_C      8'h18
`define SLLSEL_OFF_BW_D      8'h1c
`define SLLSEL_OFF_RATE_RB   8'h20
`define SLLSEL_OFF_LEVEL_RB  8'h24

`define SLLSEL_OVR_BIT       7
`define SLLSEL_LVL_MSB       6
`define SLLSEL_LVL_W         7
`define SLLSEL_BW_MSB        3
`define SLLSEL_BW_W          4

`define SLLSEL_REG_RESET     8'h00

`define SLLSEL_LVL_CODE_MIN  7'h00
`define SLLSEL_LVL_CODE_MAX  7'h7f

`define SLLSEL_LVL_A_MVPP    15
`define SLLSEL_LVL_B_MVPP    18
`define SLLSEL_LVL_C_MVPP    26
`define SLLSEL_LVL_D_MVPP    26

`define SLLSEL_PIN_SEL_A     2'b00
`define SLLSEL_PIN_SEL_B     2'b01
`define SLLSEL_PIN_SEL_C     2'b11
`define SLLSEL_PIN_SEL_D     2'b10

`endif

// ### core/sllsel_src.v
/*
 * One selectable source: a programmed code or a fixed default, chosen by
 * an override bit.
 * Assumes inputs are on the core clock domain; output is combinational.
 */
`timescale 1ns/1ps
module sllsel_src #(
	parameter         W   = 7,
	parameter [W-1:0] DEF = {W{1'b0}}
) (
	input  wire         ovr,
	input  wire [W-1:0] code,
	output wire [W-1:0] sel
);
	// Override set takes the programmed code, clear takes the default.
	assign sel = ovr ? code : DEF; // [R1] [R3]
endmodule

// ### core/sllsel_top.v
/*
 * APB register bank selecting the signal-loss assert level code and the
 * bandwidth code from four register pairs via two rate-select pins.
 * Assumes an APB master on core_clk and asynchronous rate pins.
 */
// Function
// (R1) Level register D override set: its 7-bit code is the assert level.
// (R2) Code all zeros is minimum level, all ones is maximum level.
// (R3) Level register D override clear: default 26 mVpp level is used.
// (R4) Level register D is active when high pin 1, low pin 0.
// (R5) Read-only 4-bit field reports bandwidth setting in effect; writes ignored.
// (R6) Read-only 7-bit field reports assert level code in effect; writes ignored.
// (R7) Level register A active with both pins 0; default 15 mVpp.
// (R8) Level register B active with high 0, low 1; default 18 mVpp.
// (R9) Level register C active with both pins 1; default 26 mVpp.
// (R10) Bandwidth register D active for high 1, low 0, or floating pins.
// (R11) Readback fields follow the selection continuously as pins or overrides change.
`timescale 1ns/1ps
`include "sllsel_map.vh"
module sllsel_top #(
	parameter [6:0] LVL_A_DEF = 7'h0f,
	parameter [6:0] LVL_B_DEF = 7'h12,
	parameter [6:0] LVL_C_DEF = 7'h1a,
	parameter [6:0] LVL_D_DEF = 7'h1a,
	parameter [3:0] BW_A_DEF  = 4'h2,
	parameter [3:0] BW_B_DEF  = 4'h7,
	parameter [3:0] BW_C_DEF  = 4'h8,
	parameter [3:0] BW_D_DEF  = 4'h9
) (
	input  wire        core_clk,
	input  wire        rst_n,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output wire        pslverr,
	output reg  [31:0] prdata,
	input  wire        rate_pin_high,
	input  wire        rate_pin_low,
	input  wire        rate_pins_floating,
	output reg  [6:0]  active_level_code,
	output reg  [3:0]  active_rate_code
);
	reg  [7:0] level_reg [0:3];
	reg  [7:0] bw_reg [0:3];
	reg  [2:0] pin_meta;
	reg  [2:0] pin_sync;
	wire [6:0] lvl_sel [0:3];
	wire [3:0] bw_sel [0:3];
	wire [6:0] lvl_def [0:3];
	wire [3:0] bw_def [0:3];
	reg  [1:0] src_idx;
	reg        mapped;
	reg  [31:0] next_prdata;
	wire       wr_en;
	wire       level_hit;
	wire       bw_hit;
	wire [1:0] reg_idx;
	integer    i;

	assign lvl_def[0] = LVL_A_DEF;
	assign lvl_def[1] = LVL_B_DEF;
	assign lvl_def[2] = LVL_C_DEF;
	assign lvl_def[3] = LVL_D_DEF;
	assign bw_def[0]  = BW_A_DEF;
	assign bw_def[1]  = BW_B_DEF;
	assign bw_def[2]  = BW_C_DEF;
	assign bw_def[3]  = BW_D_DEF;

	// The rate pins are asynchronous and pass two flip-flops first.
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta <= 3'h0;
			pin_sync <= 3'h0;
		end else begin
			pin_meta <= {rate_pins_floating, rate_pin_high, rate_pin_low};
			pin_sync <= pin_meta;
		end
	end

	// Pin decode picks one of the four register pairs.
	always @* begin
		if (pin_sync[2]) begin
			src_idx = 2'd3; // [R10]
		end else begin
			case (pin_sync[1:0])
				`SLLSEL_PIN_SEL_A: src_idx = 2'd0; // [R7]
				`SLLSEL_PIN_SEL_B: src_idx = 2'd1; // [R8]
				`SLLSEL_PIN_SEL_C: src_idx = 2'd2; // [R9]
				`SLLSEL_PIN_SEL_D: src_idx = 2'd3; // [R4] [R10]
				default:           src_idx = 2'd3;
			endcase
		end
	end

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : gen_src
			sllsel_src #(.W(`SLLSEL_LVL_W)) u_lvl (
				.ovr  (level_reg[g][`SLLSEL_OVR_BIT]),
				.code (level_reg[g][`SLLSEL_LVL_MSB:0]),
				.sel  (lvl_sel[g])
			);
			sllsel_src #(.W(`SLLSEL_BW_W)) u_bw (
				.ovr  (bw_reg[g][`SLLSEL_OVR_BIT]),
				.code (bw_reg[g][`SLLSEL_BW_MSB:0]),
				.sel  (bw_sel[g])
			);
		end
	endgenerate

	// Defaults are folded in here so the source module stays generic.
	wire [6:0] lvl_now = level_reg[src_idx][`SLLSEL_OVR_BIT] ? lvl_sel[src_idx]
				: lvl_def[src_idx]; // [R1] [R2] [R3]
	wire [3:0] bw_now  = bw_reg[src_idx][`SLLSEL_OVR_BIT] ? bw_sel[src_idx]
				: bw_def[src_idx];

	// Selected codes are registered every cycle and track any change.
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			active_level_code <= 7'h00;
			active_rate_code  <= 4'h0;
		end else begin
			active_level_code <= lvl_now; // [R11]
			active_rate_code  <= bw_now; // [R11]
		end
	end

	assign level_hit = (paddr[7:4] == 4'h0) && (paddr[1:0] == 2'b00);
	assign bw_hit    = (paddr[7:4] == 4'h1) && (paddr[1:0] == 2'b00);
	assign reg_idx   = paddr[3:2];

	always @* begin
		mapped = level_hit || bw_hit || (paddr == `SLLSEL_OFF_RATE_RB)
			|| (paddr == `SLLSEL_OFF_LEVEL_RB);
	end

	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign wr_en   = psel && penable && pwrite && mapped;

	// Only the eight setting registers are writable; readbacks ignore writes.
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (i = 0; i < 4; i = i + 1) begin
				level_reg[i] <= `SLLSEL_REG_RESET;
				bw_reg[i]    <= `SLLSEL_REG_RESET;
			end
		end else if (wr_en) begin
			if (level_hit) begin
				level_reg[reg_idx] <= pwdata[7:0];
			end
			if (bw_hit) begin
				bw_reg[reg_idx] <= {pwdata[7], 3'h0, pwdata[3:0]};
			end
		end
	end

	always @* begin
		next_prdata = 32'h0;
		if (level_hit) begin
			next_prdata = {24'h0, level_reg[reg_idx]};
		end else if (bw_hit) begin
			next_prdata = {24'h0, bw_reg[reg_idx]};
		end else if (paddr == `SLLSEL_OFF_RATE_RB) begin
			next_prdata = {28'h0, bw_now}; // [R5]
		end else if (paddr == `SLLSEL_OFF_LEVEL_RB) begin
			next_prdata = {25'h0, lvl_now}; // [R6]
		end
	end

	// Read data is captured in the setup cycle and stands in the access phase.
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h0;
		end else if (psel && !penable && !pwrite) begin
			prdata <= next_prdata;
		end
	end
endmodule

// ### verif/sllsel_props.sv
/* Port checker of sllsel_top. Bound to it at the foot. */
`timescale 1ns/1ps
module sllsel_props (
	input wire core_clk, rst_n, psel, penable, pwrite, pready, pslverr,
	input wire rate_pin_high, rate_pin_low, rate_pins_floating,
	input wire [7:0] paddr,
	input wire [31:0] pwdata, prdata,
	input wire [6:0] active_level_code,
	input wire [3:0] active_rate_code
);
wire acc = psel && penable;
reg [7:0] ld, bd;
wire [6:0] el = ld[7] ? ld[6:0] : 7'h1a;
wire [3:0] eb = bd[7] ? bd[3:0] : 4'h9;
always @(posedge core_clk or negedge rst_n)
	if (!rst_n) {ld, bd} <= 16'h0000;
	else if (acc && pwrite && paddr == 8'h0c) ld <= pwdata[7:0];
	else if (acc && pwrite && paddr == 8'h1c) bd <= pwdata[7:0];
default clocking @(posedge core_clk); endclocking
default disable iff (!rst_n);
property p_rdy; psel |-> pready; endproperty
a_rdy: assert property (p_rdy) else $error("bad");
property p_err; acc && paddr > 8'h24 |-> pslverr; endproperty
a_err: assert property (p_err) else $error("bad");
property p_ok; acc && paddr < 8'h25 && paddr[1:0] == 2'b00 |-> !pslverr; endproperty
a_ok: assert property (p_ok) else $error("bad");
property p_eq; pslverr |-> acc; endproperty
a_eq: assert property (p_eq) else $error("bad");
property p_rbl; acc && !pwrite && paddr == 8'h24 |-> prdata == {25'h0, active_level_code}; endproperty
a_rbl: assert property (p_rbl) else $error("bad");
property p_rbr; acc && !pwrite && paddr == 8'h20 |-> prdata == {28'h0, active_rate_code}; endproperty
a_rbr: assert property (p_rbr) else $error("bad");
property p_d; (rate_pin_high && !rate_pin_low && !rate_pins_floating) [*4]
	|-> active_level_code == $past(el); endproperty
a_d: assert property (p_d) else $error("bad");
property p_fl; rate_pins_floating [*4] |-> active_rate_code == $past(eb); endproperty
a_fl: assert property (p_fl) else $error("bad");
endmodule
bind sllsel_top sllsel_props i_props (.*);

// ### verif/tb_top.sv
/* Random bench of sllsel_top. Assumes the bound checker. */
`timescale 1ns/1ps
module tb_top;
reg core_clk, rst_n, psel, penable, pwrite, f;
reg rate_pin_high, rate_pin_low, rate_pins_floating;
reg [7:0] paddr, lv [0:3], bw [0:3];
reg [31:0] pwdata, r, rd;
reg er;
reg [1:0] s;
reg [6:0] el;
reg [3:0] eb;
wire pready, pslverr;
wire [31:0] prdata;
wire [6:0] active_level_code;
wire [3:0] active_rate_code;
integer mismatches, comparisons, k, i, n;
sllsel_top i_dut (.*);
initial begin
	core_clk = 1'b0;
	forever #2.5 core_clk = ~core_clk;
end
function [31:0] nx(input [31:0] v);
	nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
endfunction
function [6:0] exp_level(input [1:0] sel, input [7:0] v);
	exp_level = v[7] ? v[6:0] : sel[1] ? 7'h1a : sel[0] ? 7'h12 : 7'h0f;
endfunction
function [3:0] exp_rate(input [1:0] sel, input [7:0] v);
	exp_rate = v[7] ? v[3:0] : sel[1] ? {3'h4, sel[0]} : sel[0] ? 4'h7 : 4'h2;
endfunction
task conclude;
	$display("mismatches %0d comparisons %0d", mismatches, comparisons);
	if (mismatches == 0 && comparisons > 0)
		$display("DONE - PASS");
	else
		$display("DONE - FAIL");
	$finish;
endtask
task ck(input [31:0] g, e);
	comparisons = comparisons + 1;
	if (g !== e) begin
		mismatches = mismatches + 1;
		$display("ERROR %0t got %h want %h", $time, g, e);
	end
endtask
task ap(input w, input [7:0] a, input [31:0] d);
	@(posedge core_clk);
	{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
	@(posedge core_clk);
	penable <= 1'b1;
	@(posedge core_clk);
	n = 0;
	while (pready !== 1'b1 && n < 50) begin
		@(posedge core_clk);
		n = n + 1;
	end
	rd = prdata;
	er = pslverr;
	{psel, penable} <= 2'b00;
	if (n == 50) begin
		mismatches = mismatches + 1;
		$display("ERROR %0t bus wait ran out", $time);
		conclude;
	end
endtask
initial begin
	{rst_n, psel, penable, pwrite, rate_pin_high, rate_pin_low, rate_pins_floating} = 7'h00;
	{paddr, pwdata, mismatches, comparisons} = 104'h0;
	r = 32'h233c;
	repeat (6) @(posedge core_clk);
	rst_n <= 1'b1;
	for (k = 0; k < 24; k = k + 1) begin
		for (i = 0; i < 4; i = i + 1) begin
			r = nx(r);
			lv[i] = (i == 3 && k < 8 && k[1:0] == 2) ? {1'b1, {7{k[2]}}} : r[7:0];
			bw[i] = r[15:8];
			ap(1'b1, {4'h0, i[1:0], 2'b00}, {r[31:8], lv[i]});
			ap(1'b1, {4'h1, i[1:0], 2'b00}, {r[23:0], bw[i]});
		end
		ap(1'b1, 8'h20, r);
		ck({31'h0, er}, 32'h0);
		ap(1'b1, 8'h24, r);
		ck({31'h0, er}, 32'h0);
		f = k[2] & r[0];
		s = f ? 2'd3 : {k[1], k[1] ^ k[0]};
		{rate_pin_high, rate_pin_low, rate_pins_floating} <= {k[1:0], f};
		el = exp_level(s, lv[s]);
		eb = exp_rate(s, bw[s]);
		repeat (5) @(posedge core_clk);
		ck({25'h0, active_level_code}, {25'h0, el});
		ck({28'h0, active_rate_code}, {28'h0, eb});
		ap(1'b0, 8'h24, r);
		ck(rd, {25'h0, el});
		ap(1'b0, 8'h20, r);
		ck(rd, {28'h0, eb});
		ap(1'b0, {4'h0, s, 2'b00}, r);
		ck(rd, {24'h0, lv[s]});
		ap(1'b0, {4'h1, s, 2'b00}, r);
		ck(rd, {24'h0, bw[s][7], 3'h0, bw[s][3:0]});
	end
	ap(1'b0, 8'h40, r);
	ck({31'h0, er}, 32'h1);
	ck(rd, 32'h0);
	rst_n <= 1'b0;
	repeat (2) @(posedge core_clk);
	rst_n <= 1'b1;
	repeat (5) @(posedge core_clk);
	ck({25'h0, active_level_code}, {25'h0, exp_level(s, 8'h00)});
	ck({28'h0, active_rate_code}, {28'h0, exp_rate(s, 8'h00)});
	conclude;
end
endmodule
